// *** ctm_counter_timer.sv ***
// counter-timer measurement unit: event sources, four modes, result hold and register port
`timescale 1ns/1ps
`include "ctm_map.svh"
// Behaviour
// - four modes: frequency, period, interval, total; probe or state events as input.
// - frequency mode counts probe edges up to 100 MHz, state events 10 MHz.
// - period mode reports duration of one input cycle in timebase ticks.
// - total mode counts every occurrence of the selected event.
// - frequency counts over a window selectable 10 ms to 10 s.
// - period mode flags periods longer than the selected range, 10 ms to 10 s, or longer than a tenth of it with the divided source.
// - sources are direct probe, probe divided by ten, or state word.
// - state source qualifies events on a word of up to 56 bits.
// - interval mode uses separate start and stop match words.
// - probe attenuation offered only for probe sources outside interval mode.
// - threshold is an 8-bit signed code, 0.02 V per step, when probe active.
// - result refreshes continuously and live status shows while live_measure_status.
// - hold freezes the result against all but a clear, and shows frozen status instead of live.
module ctm_counter_timer #(
  parameter int unsigned STATE_W = `CTM_STATE_W,
  parameter int unsigned GATE_MIN_CYC = `CTM_GATE_MIN_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`CTM_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic probe_in,
  input wire logic state_strobe,
  input wire logic [STATE_W-1:0] state_word,
  output logic [7:0] threshold_code,
  output logic probe_x10,
  output logic probe_setting_active,
  output logic live_measure_status,
  output logic frozen_status
);
  ctm_pkg::ctm_ctrl_t ctrl;
  ctm_pkg::ctm_status_t status;
  logic [7:0] thresh;
  logic [63:0] start_word;
  logic [63:0] stop_word;
  logic clr;
  logic [2:0] probe_sync;
  logic [2:0] strobe_sync;
  logic [STATE_W-1:0] word_s1;
  logic [STATE_W-1:0] word_s2;
  logic ext_evt;
  logic divide_by_ten_input;
  logic st_edge;
  logic start_hit;
  logic stop_hit;
  logic data_evt;
  logic evt;
  logic [3:0] dec_cnt;
  logic [31:0] base_cnt;
  logic base_tick;
  logic [9:0] win_ticks;
  logic win_close;
  logic [31:0] freq_cnt;
  logic [31:0] per_cnt;
  logic armed;
  logic ovf;
  logic [31:0] range_cyc;
  logic [31:0] tot_cnt;
  logic run;
  logic [31:0] iv_cnt;
  logic [31:0] result;
  logic [31:0] next_result;
  logic pre_sel;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  function automatic logic [9:0] ctm_decade(input logic [1:0] s);
    logic [9:0] d;
    unique case (s)
      2'h0: d = 10'h001;
      2'h1: d = 10'h00A;
      2'h2: d = 10'h064;
      2'h3: d = 10'h3E8;
    endcase
    return d;
  endfunction

  // rate per second from a window count; window of 10^s times 10 ms
  function automatic logic [31:0] ctm_rate(input logic [31:0] c, input logic pre, input logic [1:0] s);
    logic [41:0] w;
    w = {10'h000, c};
    unique case ({pre, s})
      3'h0: w = w * 42'h064;
      3'h1: w = w * 42'h00A;
      3'h2: w = w;
      3'h3: w = w / 42'h00A;
      3'h4: w = w * 42'h3E8;
      3'h5: w = w * 42'h064;
      3'h6: w = w * 42'h00A;
      3'h7: w = w;
    endcase
    return w[31:0];
  endfunction

  // register port
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= ctm_pkg::ctm_ctrl_t'(`CTM_CTRL_RST);
      thresh <= `CTM_THRESH_RST;
      start_word <= `CTM_WORD_RST;
      stop_word <= `CTM_WORD_RST;
    end else if (wr) begin
      unique case (addr)
        `CTM_OFS_CTRL: ctrl <= ctm_pkg::ctm_ctrl_t'(wdata[`CTM_CTRL_W-1:0]);
        `CTM_OFS_THRESH: thresh <= wdata[7:0];
        `CTM_OFS_START_LO: start_word[31:0] <= wdata;
        `CTM_OFS_START_HI: start_word[63:32] <= wdata;
        `CTM_OFS_STOP_LO: stop_word[31:0] <= wdata;
        `CTM_OFS_STOP_HI: stop_word[63:32] <= wdata;
        default: ;
      endcase
    end
  end

  // clearing is a separate strobe so that toggling hold never wipes the reading
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clr <= 1'b0;
    end else begin
      clr <= wr && addr == `CTM_OFS_CTRL && wdata[`CTM_CTRL_CLR_BIT];
    end
  end

  always_comb begin
    status.probe_active = probe_setting_active;
    status.iv_running = run;
    status.overrange = ovf;
    status.frozen = frozen_status;
    status.live = live_measure_status;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h0;
    end else if (rd) begin
      unique case (addr)
        `CTM_OFS_CTRL: rdata <= {24'h0, ctrl};
        `CTM_OFS_THRESH: rdata <= {24'h0, thresh};
        `CTM_OFS_START_LO: rdata <= start_word[31:0];
        `CTM_OFS_START_HI: rdata <= start_word[63:32];
        `CTM_OFS_STOP_LO: rdata <= stop_word[31:0];
        `CTM_OFS_STOP_HI: rdata <= stop_word[63:32];
        `CTM_OFS_RESULT: rdata <= result;
        `CTM_OFS_STATUS: rdata <= {27'h0, status};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  // probe controls only make sense while a probe source feeds a probe mode
  // the spare source code 3 behaves as the state source, so only the two probe codes qualify
  assign probe_setting_active = ctrl.mode != ctm_pkg::CTM_INTERVAL
    && (ctrl.src == ctm_pkg::CTM_SRC_EXT || ctrl.src == ctm_pkg::CTM_SRC_PRE);
  assign probe_x10 = probe_setting_active & ctrl.probe_x10;
  assign threshold_code = probe_setting_active ? thresh : 8'h00;
  assign live_measure_status = ~ctrl.hold;
  assign frozen_status = ctrl.hold;

  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      probe_sync <= 3'h0;
      strobe_sync <= 3'h0;
      word_s1 <= '0;
      word_s2 <= '0;
    end else begin
      probe_sync <= {probe_sync[1:0], probe_in};
      strobe_sync <= {strobe_sync[1:0], state_strobe};
      word_s1 <= state_word;
      word_s2 <= word_s1;
    end
  end

  // one edge per 2 clocks limits the direct path to half the clock rate
  assign ext_evt = probe_sync[1] & ~probe_sync[2];
  assign st_edge = strobe_sync[1] & ~strobe_sync[2];
  assign start_hit = st_edge && word_s2 == start_word[STATE_W-1:0];
  assign stop_hit = st_edge && word_s2 == stop_word[STATE_W-1:0];
  assign data_evt = start_hit;
  assign divide_by_ten_input = ext_evt && dec_cnt == `CTM_PRE_LAST;
  assign pre_sel = ctrl.src == ctm_pkg::CTM_SRC_PRE;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_cnt <= 4'h0;
    end else if (clr) begin
      dec_cnt <= 4'h0;
    end else if (ext_evt) begin
      dec_cnt <= (dec_cnt == `CTM_PRE_LAST) ? 4'h0 : dec_cnt + 4'h1;
    end
  end

  always_comb begin
    unique case (ctrl.src)
      ctm_pkg::CTM_SRC_EXT: evt = ext_evt;
      ctm_pkg::CTM_SRC_PRE: evt = divide_by_ten_input;
      default: evt = data_evt;
    endcase
  end

  // 10 ms base tick, then a decade count of ticks sets window and range
  assign base_tick = base_cnt == 32'(GATE_MIN_CYC - 1);
  assign win_close = base_tick && win_ticks == ctm_decade(ctrl.win_sel) - 10'h001;
  assign range_cyc = 32'(64'(GATE_MIN_CYC) * 64'(ctm_decade(ctrl.win_sel)));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_cnt <= 32'h0;
    end else if (clr || ctrl.mode != ctm_pkg::CTM_FREQ || base_tick) begin
      base_cnt <= 32'h0;
    end else begin
      base_cnt <= base_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_ticks <= 10'h000;
      freq_cnt <= 32'h0;
    end else if (clr || ctrl.mode != ctm_pkg::CTM_FREQ) begin
      win_ticks <= 10'h000;
      freq_cnt <= 32'h0;
    end else if (win_close) begin
      win_ticks <= 10'h000;
      freq_cnt <= {31'h0, evt};
    end else begin
      if (base_tick) begin
        win_ticks <= win_ticks + 10'h001;
      end
      if (evt) begin
        freq_cnt <= freq_cnt + 32'h1;
      end
    end
  end

  // period: ticks between successive events, overrange past the range
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      per_cnt <= 32'h0;
      armed <= 1'b0;
      ovf <= 1'b0;
    end else if (clr || ctrl.mode != ctm_pkg::CTM_PERIOD) begin
      per_cnt <= 32'h0;
      armed <= 1'b0;
      ovf <= 1'b0;
    end else if (evt) begin
      per_cnt <= 32'h0;
      armed <= 1'b1;
      ovf <= 1'b0;
    end else if (armed && !ovf) begin
      if (per_cnt + 32'h1 >= range_cyc) begin
        ovf <= 1'b1;
      end else begin
        per_cnt <= per_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tot_cnt <= 32'h0;
    end else if (clr || ctrl.mode != ctm_pkg::CTM_TOTAL) begin
      tot_cnt <= 32'h0;
    end else if (evt) begin
      tot_cnt <= tot_cnt + 32'h1;
    end
  end

  // a stop match in the start cycle is ignored; only later stops end the span
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run <= 1'b0;
      iv_cnt <= 32'h0;
    end else if (clr || ctrl.mode != ctm_pkg::CTM_INTERVAL) begin
      run <= 1'b0;
      iv_cnt <= 32'h0;
    end else if (!run) begin
      if (start_hit) begin
        run <= 1'b1;
        iv_cnt <= 32'h0;
      end
    end else if (stop_hit) begin
      run <= 1'b0;
    end else begin
      iv_cnt <= iv_cnt + 32'h1;
    end
  end

  always_comb begin
    next_result = result;
    unique case (ctrl.mode)
      ctm_pkg::CTM_FREQ: if (win_close) next_result = ctm_rate(freq_cnt, pre_sel, ctrl.win_sel);
      ctm_pkg::CTM_PERIOD: if (evt && armed && !ovf) begin
        next_result = pre_sel ? (per_cnt + 32'h1) / 32'hA : per_cnt + 32'h1;
      end
      ctm_pkg::CTM_INTERVAL: if (run && stop_hit) next_result = iv_cnt + 32'h1;
      ctm_pkg::CTM_TOTAL: next_result = tot_cnt;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result <= 32'h0;
    end else if (clr) begin
      result <= 32'h0;
    end else if (!ctrl.hold) begin
      result <= next_result;
    end
  end

  sequence iv_start_s;
    ctrl.mode == ctm_pkg::CTM_INTERVAL && !run && start_hit && !clr && !wr;
  endsequence
  sequence iv_stop_s;
    ctrl.mode == ctm_pkg::CTM_INTERVAL && run && stop_hit && !clr && !ctrl.hold && !wr;
  endsequence

  hold_freeze_a: assert property (ctrl.hold && !clr |=> $stable(result))
    else $error("result changed while held");
  status_pair_a: assert property (wr && addr == `CTM_OFS_CTRL
    |=> frozen_status == $past(wdata[`CTM_CTRL_W-1]) && live_measure_status != frozen_status)
    else $error("live and frozen status do not follow hold");
  probe_gate_a: assert property (!probe_setting_active |-> threshold_code == 8'h00 && !probe_x10)
    else $error("probe setting shown without probe source");
  thresh_read_a: assert property (rd && addr == `CTM_OFS_THRESH |=> rdata == {24'h0, $past(thresh)})
    else $error("threshold readback wrong");
  total_inc_a: assert property (ctrl.mode == ctm_pkg::CTM_TOTAL && evt && !clr && !wr
    |=> tot_cnt == $past(tot_cnt) + 32'h1)
    else $error("total missed an event");
  divide_by_ten_input_skip_a: assert property (ctrl.mode == ctm_pkg::CTM_TOTAL && pre_sel && ext_evt
    && dec_cnt != `CTM_PRE_LAST && !clr && !wr |=> $stable(tot_cnt))
    else $error("divided source counted early");
  data_qual_a: assert property (ctrl.mode == ctm_pkg::CTM_TOTAL && ctrl.src == ctm_pkg::CTM_SRC_DATA
    && st_edge && !start_hit && !clr && !wr |=> $stable(tot_cnt))
    else $error("unmatched state word counted");
  freq_latch_a: assert property (ctrl.mode == ctm_pkg::CTM_FREQ && win_close && !ctrl.hold && !clr && !wr
    && !pre_sel && ctrl.win_sel == 2'h1 |=> result == $past(freq_cnt) * 32'h0000000A)
    else $error("100 ms window result wrong");
  period_val_a: assert property (ctrl.mode == ctm_pkg::CTM_PERIOD && ctrl.src == ctm_pkg::CTM_SRC_EXT
    && evt && armed && !ovf && !ctrl.hold && !clr && !wr |=> result == $past(per_cnt) + 32'h1)
    else $error("period result wrong");
  range_ovf_a: assert property (ctrl.mode == ctm_pkg::CTM_PERIOD && armed && !evt && !clr && !wr
    && per_cnt + 32'h1 >= range_cyc |=> ovf)
    else $error("overrange not flagged");
  iv_start_a: assert property (iv_start_s |=> run && iv_cnt == 32'h0)
    else $error("interval did not start");
  iv_stop_a: assert property (iv_stop_s |=> !run && result == $past(iv_cnt) + 32'h1)
    else $error("interval result wrong");
endmodule

// *** ctm_map.svh ***
// register offsets, field positions, reset values and timing counts of the counter-timer
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH
`define CTM_ADDR_W 5
`define CTM_OFS_CTRL 5'h00
`define CTM_OFS_THRESH 5'h04
`define CTM_OFS_START_LO 5'h08
`define CTM_OFS_START_HI 5'h0C
`define CTM_OFS_STOP_LO 5'h10
`define CTM_OFS_STOP_HI 5'h14
`define CTM_OFS_RESULT 5'h18
`define CTM_OFS_STATUS 5'h1C
`define CTM_CTRL_W 8
`define CTM_CTRL_CLR_BIT 8
`define CTM_STATUS_W 5
`define CTM_CTRL_RST 8'h00
`define CTM_THRESH_RST 8'h00
`define CTM_WORD_RST 64'h0
`define CTM_STATE_W 56
`define CTM_CLK_HZ 200000000
`define CTM_GATE_MIN_MS 10
`define CTM_GATE_MIN_CYC (`CTM_GATE_MIN_MS * (`CTM_CLK_HZ / 1000))
`define CTM_PRE_LAST 4'h9
`endif

// *** ctm_pkg.sv ***
// types shared by the counter-timer measurement unit
package ctm_pkg;
  typedef enum logic [1:0] {CTM_FREQ, CTM_PERIOD, CTM_INTERVAL, CTM_TOTAL} ctm_mode_t;
  typedef enum logic [1:0] {CTM_SRC_EXT, CTM_SRC_PRE, CTM_SRC_DATA} ctm_src_t;
  typedef struct packed {
    logic hold;
    logic probe_x10;
    logic [1:0] win_sel;
    ctm_src_t src;
    ctm_mode_t mode;
  } ctm_ctrl_t;
  typedef struct packed {
    logic probe_active;
    logic iv_running;
    logic overrange;
    logic frozen;
    logic live;
  } ctm_status_t;
endpackage

// *** ctm_probe_model.sv ***
// stimulus model of the probed signal and the state-probe bus
`timescale 1ns/1ps
module ctm_probe_model (
  input wire logic clk,
  output logic probe_in,
  output logic state_strobe,
  output logic [55:0] state_word
);
  initial begin
    probe_in = 1'b0;
    state_strobe = 1'b0;
    state_word = 56'h0;
  end
  // direct-probe callers keep half >= 10 cycles (10 MHz); faster only with the divided source
  task automatic edges(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge clk);
      probe_in <= 1'b1;
      repeat (half) @(posedge clk);
      probe_in <= 1'b0;
    end
  endtask
  // word settles before the strobe edge; afterwards the bus shows the inverse, so a stale word cannot match
  task automatic strobe(input logic [55:0] w);
    @(posedge clk);
    state_word <= w;
    repeat (2) @(posedge clk);
    state_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    state_strobe <= 1'b0;
    state_word <= ~w;
  endtask
endmodule

// *** counter_timer_measurement_test.sv ***
// self-checking bench of the counter-timer: register port, four modes, hold and clear
`timescale 1ns/1ps
`include "ctm_map.svh"
module counter_timer_measurement_test;
  logic clk;
  logic reset_n;
  logic [`CTM_ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic probe_in;
  logic state_strobe;
  logic [55:0] state_word;
  logic [7:0] threshold_code;
  logic probe_x10;
  logic probe_setting_active;
  logic live_measure_status;
  logic frozen_status;
  int failures;
  int tests_run;
  // rows: control byte, then expected {probe active, x10, live, frozen}
  logic [11:0] rows [7] = '{12'h40E, 12'h45E, 12'h4B2, 12'h422, 12'hCF1, 12'hC7D, 12'h30A};
  localparam logic [55:0] W_START = 56'h80123456789ABC;
  localparam logic [55:0] W_STOP = 56'h000F0FA5A5C3C3;

  // short gate keeps frequency windows at 20 cycles per step
  ctm_counter_timer #(.GATE_MIN_CYC(20)) dut_u (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .probe_in(probe_in), .state_strobe(state_strobe), .state_word(state_word),
    .threshold_code(threshold_code), .probe_x10(probe_x10), .probe_setting_active(probe_setting_active),
    .live_measure_status(live_measure_status), .frozen_status(frozen_status)
  );
  ctm_probe_model model_u (.clk(clk), .probe_in(probe_in), .state_strobe(state_strobe), .state_word(state_word));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask
  // pins pass a two-flop chain, so allow settling before reading a result
  task automatic meas(input logic [31:0] c, input int n, input int half, input logic [31:0] exp);
    reg_wr(`CTM_OFS_CTRL, c);
    model_u.edges(n, half);
    repeat (8) @(posedge clk);
    rd_chk("probe result", `CTM_OFS_RESULT, exp);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    failures = 0;
    tests_run = 0;
    reset_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk("reset outputs", {20'h0, threshold_code, probe_setting_active, probe_x10, live_measure_status,
      frozen_status}, 32'h0000000A);
    rd_chk("reset status", `CTM_OFS_STATUS, 32'h00000011);
    rd_chk("reset result", `CTM_OFS_RESULT, 32'h0);
    reg_wr(`CTM_OFS_THRESH, 32'h000000CE);
    rd_chk("thresh readback", `CTM_OFS_THRESH, 32'h000000CE);
    foreach (rows[i]) begin
      reg_wr(`CTM_OFS_CTRL, {24'h0, rows[i][11:4]});
      #1;
      chk("probe outputs", {28'h0, probe_setting_active, probe_x10, live_measure_status, frozen_status},
        {28'h0, rows[i][3:0]});
      chk("threshold", {24'h0, threshold_code}, rows[i][3] ? 32'h000000CE : 32'h0);
      rd_chk("ctrl readback", `CTM_OFS_CTRL, {24'h0, rows[i][11:4]});
    end
    // refused place: write dropped, read gives zero
    reg_wr(5'h03, 32'h000000FF);
    rd_chk("unmapped read", 5'h02, 32'h0);
    rd_chk("ctrl kept", `CTM_OFS_CTRL, 32'h00000030);
    meas(32'h00000103, 5, 10, 32'h5);
    reg_wr(`CTM_OFS_CTRL, 32'h00000083);
    model_u.edges(3, 10);
    repeat (8) @(posedge clk);
    rd_chk("held result", `CTM_OFS_RESULT, 32'h5);
    rd_chk("held status", `CTM_OFS_STATUS, 32'h00000012);
    reg_wr(`CTM_OFS_CTRL, 32'h00000183);
    repeat (2) @(posedge clk);
    rd_chk("clear in hold", `CTM_OFS_RESULT, 32'h0);
    meas(32'h00000003, 2, 10, 32'h2);
    meas(32'h00000107, 30, 2, 32'h3);
    meas(32'h00000111, 4, 12, 32'h18);
    meas(32'h00000115, 30, 2, 32'h4);
    reg_wr(`CTM_OFS_CTRL, 32'h00000101);
    model_u.edges(2, 15);
    repeat (30) @(posedge clk);
    rd_chk("overrange", `CTM_OFS_STATUS, 32'h00000015);
    reg_wr(`CTM_OFS_CTRL, 32'h00000110);
    fork
      model_u.edges(40, 10);
      begin
        repeat (500) @(posedge clk);
        rd_chk("frequency", `CTM_OFS_RESULT, 32'h00000064);
      end
    join
    reg_wr(`CTM_OFS_CTRL, 32'h00000114);
    fork
      model_u.edges(150, 2);
      begin
        repeat (500) @(posedge clk);
        rd_chk("divided frequency", `CTM_OFS_RESULT, 32'h000001F4);
      end
    join
    reg_wr(`CTM_OFS_START_LO, W_START[31:0]);
    reg_wr(`CTM_OFS_START_HI, {8'h0, W_START[55:32]});
    reg_wr(`CTM_OFS_STOP_LO, W_STOP[31:0]);
    reg_wr(`CTM_OFS_STOP_HI, {8'h0, W_STOP[55:32]});
    reg_wr(`CTM_OFS_CTRL, 32'h0000010B);
    repeat (3) model_u.strobe(W_START);
    // differs only in the top bit of the wide word
    model_u.strobe(W_START ^ 56'h80000000000000);
    repeat (6) @(posedge clk);
    rd_chk("state total", `CTM_OFS_RESULT, 32'h3);
    reg_wr(`CTM_OFS_CTRL, 32'h00000102);
    model_u.strobe(W_START);
    repeat (25) @(posedge clk);
    model_u.strobe(W_STOP);
    repeat (6) @(posedge clk);
    rd_chk("interval", `CTM_OFS_RESULT, 32'h0000001E);
    // mid-run reset must drop the interval reading and return to frequency on the probe
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk("status after reset", `CTM_OFS_STATUS, 32'h00000011);
    rd_chk("result after reset", `CTM_OFS_RESULT, 32'h0);
    close_out();
  end
endmodule
